// *** rtl/cfglc_top.sv ***
// cfglc_top: one configurable logic cell with its registers and edge flag.
// assumes data lines and gate enables come from selection logic outside,
// and that peer cell outputs arrive unsynchronised for the shared mirror.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - enable combines inputs; disabled output is zero
// - codes 000,001,010 pick AND-OR, OR-XOR, AND4
// - 011 S-R latch, 100/101 D flip-flops
// - 110 J-K flip-flop, 111 transparent latch
// - each function takes four gates, one output
// - output invert bit flips the result
// - inversion change edges raise the flag too
// - separate rise and fall detectors on output
// - rise enable lets rising edges set flag
// - fall enable lets falling edges set flag
// - software clears flag; same-cycle edge wins
// - pin driven only while pin enable set
// - read-only status bit shows cell output
// - mirror register samples all cells together
// - reset clears control, output invert and flag, not gating
// - cell logic runs without system clock
// - enabled cell keeps fast osc running when it is selected
// - each gate ANDs its directed inputs
// - gate polarity bits invert gate outputs
module cfglc_top import cfglc_pkg::*; #(
    parameter int unsigned NUM_PEER = 1
) (
    input  wire logic              CLK_SYS,         // register clock
    input  wire logic              RSTN,            // async reset, low
    input  wire logic [ADDR_W-1:0] REG_ADDR,        // register address
    input  wire logic [DATA_W-1:0] REG_WDATA,       // write data
    input  wire logic              REG_WR,          // write strobe
    input  wire logic              REG_RD,          // read strobe
    output logic      [DATA_W-1:0] REG_RDATA,       // read data, next cycle
    input  wire logic [3:0]        DATA_IN,         // selected data lines
    input  wire logic [15:0]       GATE_EN_TRUE,    // 4 bits per gate
    input  wire logic [15:0]       GATE_EN_INV,     // 4 bits per gate
    input  wire logic              FAST_OSC_SEL,    // fast osc among inputs
    input  wire logic [NUM_PEER-1:0] PEER_OUT,      // other cells' outputs
    output logic                   CELL_OUT,        // cell output to peripherals
    output logic                   CELL_PIN_O,      // pin data
    output logic                   CELL_PIN_OE_N,   // pin drive, low drives
    output logic                   CELL_IRQ_FLAG,   // sticky edge flag
    output logic                   FAST_OSC_KEEP    // keep fast osc in sleep
);

    localparam int unsigned MIR_W = NUM_PEER + 1;

    // bus decode
    logic        wr_ctl;
    logic        wr_pol;
    logic        wr_irq;
    logic        rd_hit;

    // software state
    cfglc_ctrl_s ctrl_q;
    cfglc_ctrl_s ctrl_d;
    logic        out_inv_q;
    logic [3:0]  gate_inv_q;
    logic        irq_q;
    logic        irq_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;

    // cell datapath
    logic [3:0]  gate_out;
    logic        func_y;
    logic        cell_y;

    // sampled outputs
    logic [MIR_W-1:0] mir_raw;
    logic [MIR_W-1:0] mir_s1_q;
    logic [MIR_W-1:0] mir_s2_q;
    logic             out_prev_q;
    logic             edge_rise;
    logic             edge_fall;
    logic             edge_hit;
    logic             irq_clr;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [3:0]        ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic [7:0] pad8(input logic [MIR_W-1:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < MIR_W && i < 8; i++) begin
            r[i] = v[i];
        end
        pad8 = r;
    endfunction

    // register port decode

    assign wr_ctl = REG_WR & hit(REG_ADDR, OFS_CELL_CONTROL);
    assign wr_pol = REG_WR & hit(REG_ADDR, OFS_POLARITY_REG);
    assign wr_irq = REG_WR & hit(REG_ADDR, OFS_IRQ_STATUS);
    assign rd_hit = REG_RD;

    // control register

    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctl) begin
            // status bit is not stored, so writes to it vanish
            ctrl_d.en   = REG_WDATA[CTL_EN_BIT];
            ctrl_d.oe   = REG_WDATA[CTL_OE_BIT];
            ctrl_d.rise = REG_WDATA[CTL_RISE_BIT];
            ctrl_d.fall = REG_WDATA[CTL_FALL_BIT];
            ctrl_d.mode = cfglc_mode_e'(REG_WDATA[CTL_MODE_LSB +: 3]);
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_q <= cfglc_ctrl_s'(7'h00);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // polarity register: the output bit resets, gate bits keep their value

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            out_inv_q <= OUT_INVERT_RST;
        end else if (wr_pol) begin
            out_inv_q <= REG_WDATA[POL_OUT_BIT];
        end
    end

    // no reset here on purpose: gating survives any reset
    always_ff @(posedge CLK_SYS) begin
        if (wr_pol) begin
            gate_inv_q <= REG_WDATA[POL_GATE_LSB +: 4];
        end
    end

    // data gates

    for (genvar gi = 0; gi < 4; gi++) begin : g_gate
        cfglc_gate u_gate (
            .data_i  (DATA_IN),
            .en_true (GATE_EN_TRUE[gi*4 +: 4]),
            .en_inv  (GATE_EN_INV[gi*4 +: 4]),
            .invert  (gate_inv_q[gi]),
            .gate_o  (gate_out[gi])
        );
    end

    // logic function: clockless, so it keeps running while CLK_SYS sleeps

    cfglc_func u_func (
        .run  (ctrl_q.en),
        .mode (ctrl_q.mode),
        .g    (gate_out),
        .y    (func_y)
    );

    // output polarity and enable

    assign cell_y = ctrl_q.en & (func_y ^ out_inv_q);

    assign CELL_OUT      = cell_y;
    assign CELL_PIN_O    = cell_y & ctrl_q.oe;
    assign CELL_PIN_OE_N = ~ctrl_q.oe;

    // the oscillator request ignores the system clock source entirely
    assign FAST_OSC_KEEP = ctrl_q.en & FAST_OSC_SEL;

    // synchronise own and peer outputs together; one stage feeds only the next

    assign mir_raw = {PEER_OUT, cell_y};

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            mir_s1_q <= '0;
        end else begin
            mir_s1_q <= mir_raw;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            mir_s2_q <= '0;
        end else begin
            mir_s2_q <= mir_s1_q;
        end
    end

    // edge detectors; pulses narrower than one clock can be missed

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            out_prev_q <= 1'b0;
        end else begin
            out_prev_q <= mir_s2_q[0];
        end
    end

    // an inversion change moves the output like any other edge
    assign edge_rise = mir_s2_q[0] & ~out_prev_q;
    assign edge_fall = ~mir_s2_q[0] & out_prev_q;

    assign edge_hit = (edge_rise & ctrl_q.rise)
                    | (edge_fall & ctrl_q.fall);

    // flag: write one to clear, set wins over the clear

    assign irq_clr = wr_irq & REG_WDATA[IRQ_FLAG_BIT];

    always_comb begin
        irq_d = irq_q;
        if (irq_clr) begin
            irq_d = 1'b0;
        end
        if (edge_hit) begin
            irq_d = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign CELL_IRQ_FLAG = irq_q;

    // read path; mirror is one sample of all cells, no skew between them

    always_comb begin
        rdata_d = RDATA_RST;
        if (rd_hit) begin
            if (hit(REG_ADDR, OFS_CELL_CONTROL)) begin
                rdata_d[CTL_EN_BIT]             = ctrl_q.en;
                rdata_d[CTL_OE_BIT]             = ctrl_q.oe;
                rdata_d[CTL_OUT_BIT]            = mir_s2_q[0];
                rdata_d[CTL_RISE_BIT]           = ctrl_q.rise;
                rdata_d[CTL_FALL_BIT]           = ctrl_q.fall;
                rdata_d[CTL_MODE_LSB +: 3]      = ctrl_q.mode;
            end else if (hit(REG_ADDR, OFS_POLARITY_REG)) begin
                rdata_d[POL_OUT_BIT]            = out_inv_q;
                rdata_d[POL_GATE_LSB +: 4]      = gate_inv_q;
            end else if (hit(REG_ADDR, OFS_OUTPUT_MIRROR)) begin
                rdata_d                         = pad8(mir_s2_q);
            end else if (hit(REG_ADDR, OFS_IRQ_STATUS)) begin
                rdata_d[IRQ_FLAG_BIT]           = irq_q;
            end
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            rdata_q <= RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign REG_RDATA = rdata_q;

endmodule // cfglc_top
`default_nettype wire

// *** rtl/cfglc_pkg.sv ***
// cfglc_pkg: offsets, field positions, reset values and types of the logic cell.
// assumes an 8-bit register port with a 4-bit word address.
package cfglc_pkg;

    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 8;

    localparam logic [3:0] OFS_CELL_CONTROL  = 4'h0;
    localparam logic [3:0] OFS_POLARITY_REG  = 4'h1;
    localparam logic [3:0] OFS_OUTPUT_MIRROR = 4'h2;
    localparam logic [3:0] OFS_IRQ_STATUS    = 4'h3;

    localparam int unsigned CTL_EN_BIT   = 7;
    localparam int unsigned CTL_OE_BIT   = 6;
    localparam int unsigned CTL_OUT_BIT  = 5;
    localparam int unsigned CTL_RISE_BIT = 4;
    localparam int unsigned CTL_FALL_BIT = 3;
    localparam int unsigned CTL_MODE_LSB = 0;
    localparam int unsigned POL_OUT_BIT  = 7;
    localparam int unsigned POL_GATE_LSB = 0;
    localparam int unsigned IRQ_FLAG_BIT = 0;

    localparam logic [7:0] CELL_CONTROL_RST = 8'h00;
    localparam logic       OUT_INVERT_RST   = 1'b0;
    localparam logic [7:0] RDATA_RST        = 8'h00;

    typedef enum logic [2:0] {
        MODE_AND_OR = 3'b000,
        MODE_OR_XOR = 3'b001,
        MODE_AND4   = 3'b010,
        MODE_SR     = 3'b011,
        MODE_DFF_SR = 3'b100,
        MODE_DFF2_R = 3'b101,
        MODE_JK_R   = 3'b110,
        MODE_LAT_SR = 3'b111
    } cfglc_mode_e;

    typedef struct packed {
        logic        en;
        logic        oe;
        logic        rise;
        logic        fall;
        cfglc_mode_e mode;
    } cfglc_ctrl_s;

endpackage

// *** rtl/cfglc_gate.sv ***
// cfglc_gate: one data gate, an AND of the directed inputs plus output polarity.
// assumes enables come from gate-enable registers kept outside this block.
`timescale 1ns/10ps
`default_nettype none
module cfglc_gate import cfglc_pkg::*; (
    input  wire logic [3:0] data_i,   // selected data lines
    input  wire logic [3:0] en_true,  // direct each line as is
    input  wire logic [3:0] en_inv,   // direct each line inverted
    input  wire logic       invert,   // gate output polarity
    output logic            gate_o    // to the function stage
);
    logic any_sel;
    logic prod;

    // an empty gate gives zero, so polarity alone picks the constant
    assign any_sel = |(en_true | en_inv);
    assign prod    = &(~en_true | data_i) & &(~en_inv | ~data_i);
    assign gate_o  = (any_sel & prod) ^ invert;
endmodule // cfglc_gate
`default_nettype wire

// *** rtl/cfglc_func.sv ***
// cfglc_func: the eight selectable functions of the cell, built without CLK_SYS.
// assumes run low holds every storage element cleared.
`timescale 1ns/10ps
`default_nettype none
module cfglc_func import cfglc_pkg::*; (
    input  wire logic        run,    // cell enable
    input  wire cfglc_mode_e mode,   // function select
    input  wire logic [3:0]  g,      // gate outputs 1..4
    output logic             y       // function result
);
    logic rst_a;
    logic set_a;
    logic sr_s;
    logic sr_r;
    logic q_sr;
    logic q_d1;
    logic q_d2;
    logic q_jk;
    logic q_lat;

    // gate 3 resets, gate 4 sets in modes 100 and 111; disabling the cell clears all state
    assign rst_a = g[2] | ~run;
    assign set_a = g[3] & run;
    assign sr_s  = (g[0] | g[1]) & run;
    assign sr_r  = g[2] | g[3] | ~run;

    always_latch begin
        if (sr_r) q_sr = 1'b0;
        else if (sr_s) q_sr = 1'b1;
    end

    always_ff @(posedge g[0] or posedge rst_a or posedge set_a) begin
        if (rst_a) q_d1 <= 1'b0;
        else if (set_a) q_d1 <= 1'b1;
        else q_d1 <= g[1];
    end

    always_ff @(posedge g[0] or posedge rst_a) begin
        if (rst_a) q_d2 <= 1'b0;
        else q_d2 <= g[1] & g[3];
    end

    always_ff @(posedge g[0] or posedge rst_a) begin
        if (rst_a) q_jk <= 1'b0;
        else q_jk <= (g[1] & ~q_jk) | (~g[3] & q_jk);
    end

    always_latch begin
        if (rst_a) q_lat = 1'b0;
        else if (set_a) q_lat = 1'b1;
        else if (g[0]) q_lat = g[1];
    end

    always_comb begin
        unique case (mode)
            MODE_AND_OR: y = (g[0] & g[1]) | (g[2] & g[3]);
            MODE_OR_XOR: y = (g[0] | g[1]) ^ (g[2] | g[3]);
            MODE_AND4:   y = &g;
            MODE_SR:     y = q_sr;
            MODE_DFF_SR: y = q_d1;
            MODE_DFF2_R: y = q_d2;
            MODE_JK_R:   y = q_jk;
            MODE_LAT_SR: y = q_lat;
        endcase
    end
endmodule // cfglc_func
`default_nettype wire

// *** dv/cfglc_props.sv ***
// cfglc_props: concurrent checks on the logic cell top ports.
// assumes it is bound into cfglc_top and sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module cfglc_props import cfglc_pkg::*; #(
    parameter int unsigned NUM_PEER = 1
) (
    input wire logic                CLK_SYS,       // clock
    input wire logic                RSTN,          // reset, low
    input wire logic [ADDR_W-1:0]   REG_ADDR,      // address
    input wire logic [DATA_W-1:0]   REG_WDATA,     // write data
    input wire logic                REG_WR,        // write strobe
    input wire logic                REG_RD,        // read strobe
    input wire logic [DATA_W-1:0]   REG_RDATA,     // read data
    input wire logic                FAST_OSC_SEL,  // osc selected
    input wire logic [NUM_PEER-1:0] PEER_OUT,      // peer outputs
    input wire logic                CELL_OUT,      // cell output
    input wire logic                CELL_PIN_O,    // pin data
    input wire logic                CELL_PIN_OE_N, // pin drive, low
    input wire logic                CELL_IRQ_FLAG, // edge flag
    input wire logic                FAST_OSC_KEEP  // osc keep
);
    logic [7:0] ctl_q;
    logic       clr_w;
    logic       rd_ctl;
    assign clr_w  = REG_WR && REG_ADDR == OFS_IRQ_STATUS && REG_WDATA[IRQ_FLAG_BIT];
    assign rd_ctl = REG_RD && REG_ADDR == OFS_CELL_CONTROL;
    // shadow of control writes, so outputs can be tied to their cause
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ctl_q <= CELL_CONTROL_RST;
        end else if (REG_WR && REG_ADDR == OFS_CELL_CONTROL) begin
            ctl_q <= REG_WDATA;
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RSTN);
    AST_DISABLE_ZERO: assert property (!ctl_q[CTL_EN_BIT] |-> !CELL_OUT)
        else $error("cell output high while disabled");
    AST_OSC_KEEP: assert property (FAST_OSC_KEEP == (ctl_q[CTL_EN_BIT] && FAST_OSC_SEL))
        else $error("fast osc keep wrong");
    AST_PIN_OE: assert property (CELL_PIN_OE_N == !ctl_q[CTL_OE_BIT])
        else $error("pin drive enable wrong");
    AST_PIN_DATA: assert property (CELL_PIN_O == (CELL_OUT && ctl_q[CTL_OE_BIT]))
        else $error("pin data wrong");
    AST_CTRL_READ: assert property (rd_ctl |=> REG_RDATA[4:0] == ctl_q[4:0]
        && REG_RDATA[7:6] == ctl_q[7:6]) else $error("control readback wrong");
    AST_STATUS: assert property ($stable(CELL_OUT)[*4] ##0 rd_ctl
        |=> REG_RDATA[CTL_OUT_BIT] == $past(CELL_OUT)) else $error("status bit wrong");
    AST_MIRROR: assert property ($stable({PEER_OUT, CELL_OUT})[*4] ##0 (REG_RD
        && REG_ADDR == OFS_OUTPUT_MIRROR) |=> REG_RDATA[NUM_PEER:0] == $past({PEER_OUT, CELL_OUT}))
        else $error("mirror read wrong");
    AST_RISE_FLAG: assert property ((ctl_q[CTL_RISE_BIT] && $rose(CELL_OUT)) ##1
        (CELL_OUT && ctl_q[CTL_RISE_BIT])[*2] |-> ##[0:3] CELL_IRQ_FLAG)
        else $error("rising edge did not set flag");
    AST_FALL_FLAG: assert property ((ctl_q[CTL_FALL_BIT] && $fell(CELL_OUT)) ##1
        (!CELL_OUT && ctl_q[CTL_FALL_BIT])[*2] |-> ##[0:3] CELL_IRQ_FLAG)
        else $error("falling edge did not set flag");
    AST_FLAG_STICKY: assert property (CELL_IRQ_FLAG && !clr_w |=> CELL_IRQ_FLAG)
        else $error("flag dropped without clear");
    cover property ($rose(CELL_IRQ_FLAG));
    cover property (clr_w && CELL_IRQ_FLAG);
    cover property (REG_RD && REG_ADDR == OFS_OUTPUT_MIRROR);
endmodule // cfglc_props

bind cfglc_top cfglc_props #(.NUM_PEER(NUM_PEER)) u_props (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FAST_OSC_SEL(FAST_OSC_SEL),
    .PEER_OUT(PEER_OUT), .CELL_OUT(CELL_OUT), .CELL_PIN_O(CELL_PIN_O),
    .CELL_PIN_OE_N(CELL_PIN_OE_N), .CELL_IRQ_FLAG(CELL_IRQ_FLAG),
    .FAST_OSC_KEEP(FAST_OSC_KEEP));
`default_nettype wire

// *** dv/cfglc_far_model.sv ***
// cfglc_far_model: the pad with its pull-up and one peer cell.
// assumes the bench steers the peer cell level.
`timescale 1ns/10ps
`default_nettype none
module cfglc_far_model (
    input  wire logic pin_o,      // cell pin data
    input  wire logic pin_oe_n,   // low while the cell drives
    input  wire logic peer_level, // wanted peer level
    output logic      pin_level,  // resolved pad level
    output logic      peer_out    // peer cell output
);
    // released pad floats up, never keeps the last driven value
    assign pin_level = pin_oe_n ? 1'b1 : pin_o;
    assign peer_out  = peer_level;
endmodule // cfglc_far_model
`default_nettype wire

// *** dv/configurable_logic_cell_tb.sv ***
// configurable_logic_cell_tb: self-checking bench for one logic cell.
// assumes cfglc_far_model stands for the pad and a peer cell.
`timescale 1ns/10ps
`default_nettype none
module configurable_logic_cell_tb import cfglc_pkg::*;;
    logic        clk_sys, rstn, reg_wr, reg_rd, osc_sel, peer_lvl;
    logic [3:0]  reg_addr, din;
    logic [7:0]  reg_wdata, rdata;
    logic [15:0] gtrue, gneg;
    logic        cell_out, pin_o, pin_oe_n, irq_flag, osc_keep, pin_lvl, peer_out;
    int          errors, checks;
    // {mode, invert, data lines g4..g1, expected output}
    logic [15:0] rows [37] = '{16'h0031, 16'h0050, 16'h01c0, 16'h1011, 16'h1050, 16'h20f1,
        16'h2070, 16'h2171, 16'h3040, 16'h3011, 16'h3001, 16'h3080, 16'h4040, 16'h4020,
        16'h4031, 16'h4001, 16'h4010, 16'h4081, 16'h4001, 16'h5040, 16'h50a0, 16'h50b1,
        16'h5021, 16'h5030, 16'h6040, 16'h6020, 16'h6031, 16'h60a1, 16'h60b0, 16'h6080,
        16'h6090, 16'h7040, 16'h7031, 16'h7010, 16'h7000, 16'h7020, 16'h7081};

    cfglc_top dut (.CLK_SYS(clk_sys), .RSTN(rstn), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata),
        .DATA_IN(din), .GATE_EN_TRUE(gtrue), .GATE_EN_INV(gneg), .FAST_OSC_SEL(osc_sel),
        .PEER_OUT(peer_out), .CELL_OUT(cell_out), .CELL_PIN_O(pin_o),
        .CELL_PIN_OE_N(pin_oe_n), .CELL_IRQ_FLAG(irq_flag), .FAST_OSC_KEEP(osc_keep));
    cfglc_far_model u_far (.pin_o(pin_o), .pin_oe_n(pin_oe_n), .peer_level(peer_lvl),
        .pin_level(pin_lvl), .peer_out(peer_out));

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [7:0] e, input string what);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        chk(what, rdata, e);
        // read data must drop back to zero once its one cycle is over
        @(negedge clk_sys);
        chk("rdata idle", rdata, 8'h00);
    endtask
    // new data lines, output looked at before any clock edge passes
    task automatic put(input logic [3:0] v, input logic e);
        @(posedge clk_sys);
        din <= v;
        #2;
        chk("cell_out", 8'(cell_out), 8'(e));
    endtask
    task automatic flag_after(input logic [3:0] v, input logic e);
        wr(OFS_IRQ_STATUS, 8'h01);
        @(posedge clk_sys);
        din <= v;
        repeat (5) @(posedge clk_sys);
        #1;
        chk("irq_flag", 8'(irq_flag), 8'(e));
    endtask
    task automatic give_verdict();
        if (errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // the whole sequence needs well under 2000 cycles
    initial begin
        #100000;
        errors++;
        give_verdict();
    end
    initial begin
        rstn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00;
        din = 4'h0; gtrue = 16'h8421; gneg = 16'h0000; osc_sel = 1'b0; peer_lvl = 1'b0;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        rdchk(OFS_CELL_CONTROL, 8'h00, "control reset");
        foreach (rows[i]) begin
            wr(OFS_CELL_CONTROL, {5'b10000, rows[i][14:12]});
            wr(OFS_POLARITY_REG, {rows[i][8], 7'h00});
            put(rows[i][7:4], rows[i][0]);
        end
        wr(OFS_CELL_CONTROL, 8'h82);
        @(posedge clk_sys);
        gtrue <= 16'hffff;
        put(4'hf, 1'b1);
        put(4'he, 1'b0);
        @(posedge clk_sys);
        gtrue <= 16'h0000;
        gneg  <= 16'hffff;
        put(4'h0, 1'b1);
        @(posedge clk_sys);
        gneg <= 16'h0000;
        wr(OFS_POLARITY_REG, 8'h0f);
        put(4'h0, 1'b1);
        wr(OFS_POLARITY_REG, 8'h87);
        put(4'h0, 1'b1);
        @(posedge clk_sys);
        gtrue <= 16'h8421;
        osc_sel <= 1'b1;
        wr(OFS_CELL_CONTROL, 8'h02);
        put(4'h0, 1'b0);
        chk("osc_keep", 8'(osc_keep), 8'h00);
        wr(OFS_POLARITY_REG, 8'h00);
        wr(OFS_CELL_CONTROL, 8'hc2);
        chk("osc_keep", 8'(osc_keep), 8'h01);
        put(4'hf, 1'b1);
        chk("pin", 8'(pin_lvl), 8'h01);
        put(4'h0, 1'b0);
        chk("pin", 8'(pin_lvl), 8'h00);
        wr(OFS_CELL_CONTROL, 8'ha2);
        chk("pin_oe_n", 8'(pin_oe_n), 8'h01);
        @(posedge clk_sys);
        peer_lvl <= 1'b1;
        put(4'hf, 1'b1);
        repeat (4) @(posedge clk_sys);
        rdchk(OFS_CELL_CONTROL, 8'ha2, "status");
        rdchk(OFS_OUTPUT_MIRROR, 8'h03, "mirror");
        put(4'h0, 1'b0);
        repeat (4) @(posedge clk_sys);
        rdchk(OFS_CELL_CONTROL, 8'h82, "status");
        rdchk(OFS_OUTPUT_MIRROR, 8'h02, "mirror");
        rdchk(4'h9, 8'h00, "unmapped");
        wr(OFS_CELL_CONTROL, 8'h02);
        wr(OFS_CELL_CONTROL, 8'h92);
        flag_after(4'hf, 1'b1);
        flag_after(4'h0, 1'b0);
        wr(OFS_CELL_CONTROL, 8'h8a);
        flag_after(4'hf, 1'b0);
        flag_after(4'h0, 1'b1);
        wr(OFS_IRQ_STATUS, 8'h01);
        chk("irq_flag", 8'(irq_flag), 8'h00);
        // falling edge reaches the flag on the very edge that takes the clear
        put(4'hf, 1'b1);
        repeat (4) @(posedge clk_sys);
        din <= 4'h0;
        @(posedge clk_sys);
        wr(OFS_IRQ_STATUS, 8'h01);
        chk("irq_flag set wins", 8'(irq_flag), 8'h01);
        wr(OFS_IRQ_STATUS, 8'h01);
        chk("irq_flag", 8'(irq_flag), 8'h00);
        wr(OFS_POLARITY_REG, 8'h80);
        repeat (5) @(posedge clk_sys);
        wr(OFS_POLARITY_REG, 8'h05);
        repeat (5) @(posedge clk_sys);
        #1;
        chk("irq_flag", 8'(irq_flag), 8'h01);
        wr(OFS_POLARITY_REG, 8'h85);
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        rdchk(OFS_CELL_CONTROL, 8'h00, "control reset");
        rdchk(OFS_POLARITY_REG, 8'h05, "gate polarity kept");
        give_verdict();
    end
endmodule // configurable_logic_cell_tb
`default_nettype wire
